/* sdi_init.sv */
// SDRAM power-on initialisation sequencer with its register port
// Operation
// - Mode-load bit programs burst 8, interleaved, CAS latency 3 into all SDRAMs.
// - No mode-register write while the mode-load bit is zero.
// - Precharge bit issues two back-to-back precharges to every SDRAM range.
// - Precharge bit self-clears after the second precharge.
// - Refresh bit issues eight back-to-back CBR refreshes to SDRAM ranges.
// - Initial refreshes only when some range is typed SDRAM.
// - Refresh bit also enables periodic DRAM refresh in all ranges.
// - Refresh bit resets to zero and self-clears after the eighth refresh.
// - Init control word sits at 0x78 and resets to zero.
// - Refresh interval counts down a 12-bit value, pulsing at zero.
`timescale 1ns/10ps
`default_nettype none
`include "sdi_params.svh"
module sdi_init (
  input  wire logic                          clk_sys,
  input  wire logic                          rstn,
  input  wire logic [`SDI_AW-1:0]            reg_addr,
  input  wire logic [`SDI_DW-1:0]            reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output var  sdi_pkg::sdi_word_t            reg_rdata,
  output var  logic [`SDI_RANGES-1:0]        sd_cs_n,
  output var  logic                          sd_ras_n,
  output var  logic                          sd_cas_n,
  output var  logic                          sd_we_n,
  output var  logic [`SDI_SA_W-1:0]          sd_addr,
  output var  logic                          init_busy,
  output var  logic                          dram_refresh_en,
  output var  logic                          refresh_pulse
);
  import sdi_pkg::*;

  // ****************************************
  // Helper functions
  // ****************************************
  function automatic logic [3:0] op_count(input sdi_op_e op);
    case (op)
      SDI_OP_PRE: op_count = `SDI_PRE_COUNT;
      SDI_OP_REF: op_count = `SDI_REF_COUNT;
      SDI_OP_MRS: op_count = `SDI_MRS_COUNT;
      default:    op_count = `SDI_MRS_COUNT;
    endcase
  endfunction : op_count

  function automatic logic [3:0] op_gap(input sdi_op_e op);
    case (op)
      SDI_OP_PRE: op_gap = `SDI_PRE_GAP;
      SDI_OP_REF: op_gap = `SDI_REF_GAP;
      SDI_OP_MRS: op_gap = `SDI_MRS_GAP;
      default:    op_gap = `SDI_MRS_GAP;
    endcase
  endfunction : op_gap

  function automatic logic [`SDI_INIT_W-1:0] op_bit(input sdi_op_e op);
    case (op)
      SDI_OP_PRE: op_bit = `SDI_INIT_W'(1 << `SDI_BIT_PRE);
      SDI_OP_REF: op_bit = `SDI_INIT_W'(1 << `SDI_BIT_REF);
      SDI_OP_MRS: op_bit = `SDI_INIT_W'(1 << `SDI_BIT_MODE);
      default:    op_bit = `SDI_INIT_W'(0);
    endcase
  endfunction : op_bit

  function automatic logic hit(input logic [`SDI_AW-1:0] a, input logic [`SDI_AW-1:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // ****************************************
  // State
  // ****************************************
  sdi_regs_s r_r;
  sdi_regs_s r_nxt;

  logic                   any_sdram;
  logic [`SDI_INIT_W-1:0] set_bits;
  logic [`SDI_INIT_W-1:0] clr_bits;

  assign any_sdram = |r_r.memtype;

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    r_nxt            = r_r;
    r_nxt.cs_n       = {`SDI_RANGES{1'b1}};
    r_nxt.ras_n      = 1'b1;
    r_nxt.cas_n      = 1'b1;
    r_nxt.we_n       = 1'b1;
    r_nxt.sa         = '0;
    r_nxt.rfsh_pulse = 1'b0;
    r_nxt.rdata      = '0;
    set_bits         = '0;
    clr_bits         = '0;

    // Register writes; trigger bits only set by writing one
    if (reg_wr) begin
      if (hit(reg_addr, `SDI_OFS_INIT)) begin
        set_bits = reg_wdata[`SDI_INIT_W-1:0];
      end
      if (hit(reg_addr, `SDI_OFS_REFCNT)) begin
        r_nxt.interval = reg_wdata[`SDI_REFCNT_W-1:0];
        r_nxt.down     = reg_wdata[`SDI_REFCNT_W-1:0];
      end
      if (hit(reg_addr, `SDI_OFS_MEMTYPE)) begin
        r_nxt.memtype = reg_wdata[`SDI_RANGES-1:0];
      end
    end
    if (reg_wr && hit(reg_addr, `SDI_OFS_INIT) && reg_wdata[`SDI_BIT_REF]) begin
      r_nxt.ref_en = 1'b1;
    end

    // Command sequencer
    case (r_r.st)
      SDI_ST_IDLE: begin
        if (r_r.init[`SDI_BIT_PRE]) begin
          r_nxt.op   = SDI_OP_PRE;
          r_nxt.done = '0;
          r_nxt.st   = SDI_ST_ISSUE;
          r_nxt.busy = 1'b1;
        end else if (r_r.init[`SDI_BIT_REF]) begin
          if (any_sdram) begin
            r_nxt.op   = SDI_OP_REF;
            r_nxt.done = '0;
            r_nxt.st   = SDI_ST_ISSUE;
            r_nxt.busy = 1'b1;
          end else begin
            clr_bits[`SDI_BIT_REF] = 1'b1;
          end
        end else if (r_r.init[`SDI_BIT_MODE]) begin
          r_nxt.op   = SDI_OP_MRS;
          r_nxt.done = '0;
          r_nxt.st   = SDI_ST_ISSUE;
          r_nxt.busy = 1'b1;
        end else begin
          r_nxt.busy = 1'b0;
        end
      end
      SDI_ST_ISSUE: begin
        r_nxt.cs_n  = ~r_r.memtype;
        r_nxt.ras_n = 1'b0;
        case (r_r.op)
          SDI_OP_PRE: begin
            r_nxt.we_n = 1'b0;
            r_nxt.sa   = `SDI_A10_ALL;
          end
          SDI_OP_REF: begin
            r_nxt.cas_n = 1'b0;
          end
          SDI_OP_MRS: begin
            r_nxt.cas_n = 1'b0;
            r_nxt.we_n  = 1'b0;
            r_nxt.sa    = `SDI_MODE_WORD;
          end
          default: begin
            r_nxt.cs_n = {`SDI_RANGES{1'b1}};
          end
        endcase
        r_nxt.done = r_r.done + 4'h1;
        r_nxt.gap  = op_gap(r_r.op);
        r_nxt.st   = SDI_ST_GAP;
      end
      SDI_ST_GAP: begin
        if (r_r.gap > 4'h1) begin
          r_nxt.gap = r_r.gap - 4'h1;
        end else if (r_r.done == op_count(r_r.op)) begin
          clr_bits = op_bit(r_r.op);
          r_nxt.st = SDI_ST_IDLE;
        end else begin
          r_nxt.st = SDI_ST_ISSUE;
        end
      end
      default: begin
        r_nxt.st = SDI_ST_IDLE;
      end
    endcase

    // Set wins over the self-clear
    r_nxt.init = (r_r.init & ~clr_bits) | set_bits;

    // Periodic refresh interval counter
    if (r_r.ref_en && (r_r.interval != '0)) begin
      if (r_r.down == '0) begin
        r_nxt.rfsh_pulse = 1'b1;
        r_nxt.down       = r_r.interval;
      end else begin
        r_nxt.down = r_r.down - `SDI_REFCNT_W'(1);
      end
    end

    // Read data, valid the cycle after the strobe
    if (reg_rd) begin
      case (reg_addr)
        `SDI_OFS_INIT:    r_nxt.rdata = sdi_word_t'(r_r.init);
        `SDI_OFS_REFCNT:  r_nxt.rdata = sdi_word_t'(r_r.interval);
        `SDI_OFS_MEMTYPE: r_nxt.rdata = sdi_word_t'(r_r.memtype);
        `SDI_OFS_STATUS:  r_nxt.rdata = sdi_word_t'({r_r.down, 2'b00, r_r.ref_en, r_r.busy});
        default:          r_nxt.rdata = '0;
      endcase
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      r_r.st         <= SDI_ST_IDLE;
      r_r.op         <= SDI_OP_PRE;
      r_r.done       <= '0;
      r_r.gap        <= '0;
      r_r.init       <= `SDI_INIT_RST;
      r_r.ref_en     <= 1'b0;
      r_r.interval   <= `SDI_REFCNT_RST;
      r_r.down       <= `SDI_REFCNT_RST;
      r_r.memtype    <= `SDI_MEMTYPE_RST;
      r_r.cs_n       <= {`SDI_RANGES{1'b1}};
      r_r.ras_n      <= 1'b1;
      r_r.cas_n      <= 1'b1;
      r_r.we_n       <= 1'b1;
      r_r.sa         <= '0;
      r_r.busy       <= 1'b0;
      r_r.rfsh_pulse <= 1'b0;
      r_r.rdata      <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign reg_rdata       = r_r.rdata;
  assign sd_cs_n         = r_r.cs_n;
  assign sd_ras_n        = r_r.ras_n;
  assign sd_cas_n        = r_r.cas_n;
  assign sd_we_n         = r_r.we_n;
  assign sd_addr         = r_r.sa;
  assign init_busy       = r_r.busy;
  assign dram_refresh_en = r_r.ref_en;
  assign refresh_pulse   = r_r.rfsh_pulse;

endmodule : sdi_init
`default_nettype wire

/* sdi_init_chk.sv */
// Port-level assertions for the SDRAM init sequencer
`timescale 1ns/10ps
`default_nettype none
`include "sdi_params.svh"
module sdi_init_chk (
  input wire logic                   clk_sys,
  input wire logic                   rstn,
  input wire logic [`SDI_AW-1:0]     reg_addr,
  input wire logic [`SDI_DW-1:0]     reg_wdata,
  input wire logic                   reg_wr,
  input wire logic [`SDI_RANGES-1:0] sd_cs_n,
  input wire logic                   sd_ras_n,
  input wire logic                   sd_cas_n,
  input wire logic                   sd_we_n,
  input wire logic [`SDI_SA_W-1:0]   sd_addr,
  input wire logic                   init_busy,
  input wire logic                   dram_refresh_en,
  input wire logic                   refresh_pulse
);
  // ****
  // Command decode and refresh tally
  // ****
  wire logic cmd_v   = !(&sd_cs_n) && !sd_ras_n;
  wire logic pre_c   = cmd_v && sd_cas_n && !sd_we_n;
  wire logic ref_c   = cmd_v && !sd_cas_n && sd_we_n;
  wire logic mrs_c   = cmd_v && !sd_cas_n && !sd_we_n;
  wire logic init_wr = reg_wr && reg_addr == `SDI_OFS_INIT && !init_busy;
  logic [3:0] ref_cnt_r;
  always_ff @(posedge clk_sys) begin
    if (!rstn || !init_busy) ref_cnt_r <= 4'h0;
    else if (ref_c) ref_cnt_r <= ref_cnt_r + 4'h1;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  sequence s_pre_pair; pre_c ##3 pre_c; endsequence
  sequence s_mrs_once; mrs_c && sd_addr == `SDI_MODE_WORD ##1 (!mrs_c) [*8]; endsequence
  AST_PRE_PAIR: assert property (init_wr && reg_wdata[1] |-> ##3 s_pre_pair)
    else $error("precharge pair missing");
  AST_PRE_ADDR: assert property (pre_c |-> sd_addr == `SDI_A10_ALL)
    else $error("precharge without all-bank address");
  AST_MRS_ONCE: assert property (init_wr && reg_wdata[2:0] == 3'h1 |-> ##3 s_mrs_once)
    else $error("mode load wrong");
  AST_MRS_CAUSE: assert property (mrs_c |-> $past(reg_wr, 3) && $past(reg_wdata[0], 3))
    else $error("mode load without request");
  AST_REF_EIGHT: assert property ($fell(init_busy) |-> ref_cnt_r == 4'h0 || ref_cnt_r == 4'h8)
    else $error("refresh burst count wrong");
  AST_CMD_BUSY: assert property (pre_c || ref_c || mrs_c |-> init_busy)
    else $error("command outside busy");
  AST_REF_EN: assert property (init_wr && reg_wdata[2] |-> ##[1:4] dram_refresh_en)
    else $error("refresh enable not set");
  AST_EN_HOLD: assert property (dram_refresh_en |=> dram_refresh_en)
    else $error("refresh enable dropped");
  AST_PULSE: assert property (refresh_pulse |-> dram_refresh_en ##1 !refresh_pulse)
    else $error("refresh pulse wrong");
endmodule : sdi_init_chk
`default_nettype wire

/* sdi_params.svh */
// Constants of the SDRAM power-on initialisation block
`ifndef SDI_PARAMS_SVH
`define SDI_PARAMS_SVH

`define SDI_AW            8
`define SDI_DW            32
`define SDI_RANGES        5
`define SDI_SA_W          14

`define SDI_OFS_REFCNT    8'h58
`define SDI_OFS_INIT      8'h78
`define SDI_OFS_MEMTYPE   8'h7C
`define SDI_OFS_STATUS    8'h80

`define SDI_BIT_MODE      0
`define SDI_BIT_PRE       1
`define SDI_BIT_REF       2
`define SDI_INIT_W        3
`define SDI_INIT_RST      3'h0
`define SDI_REFCNT_W      12
`define SDI_REFCNT_RST    12'h000
`define SDI_MEMTYPE_RST   5'h00

`define SDI_PRE_COUNT     4'h2
`define SDI_REF_COUNT     4'h8
`define SDI_MRS_COUNT     4'h1
`define SDI_PRE_GAP       4'h2
`define SDI_REF_GAP       4'h6
`define SDI_MRS_GAP       4'h6

`define SDI_MODE_WORD     14'h003B
`define SDI_A10_ALL       14'h0400

`endif

/* sdi_pkg.sv */
// Types of the SDRAM power-on initialisation block
`default_nettype none
`include "sdi_params.svh"
package sdi_pkg;

  typedef enum logic [1:0] {
    SDI_ST_IDLE,
    SDI_ST_ISSUE,
    SDI_ST_GAP
  } sdi_state_e;

  typedef enum logic [1:0] {
    SDI_OP_PRE,
    SDI_OP_REF,
    SDI_OP_MRS
  } sdi_op_e;

  typedef logic [`SDI_DW-1:0] sdi_word_t;

  typedef struct packed {
    sdi_state_e                st;
    sdi_op_e                   op;
    logic [3:0]                done;
    logic [3:0]                gap;
    logic [`SDI_INIT_W-1:0]    init;
    logic                      ref_en;
    logic [`SDI_REFCNT_W-1:0]  interval;
    logic [`SDI_REFCNT_W-1:0]  down;
    logic [`SDI_RANGES-1:0]    memtype;
    logic [`SDI_RANGES-1:0]    cs_n;
    logic                      ras_n;
    logic                      cas_n;
    logic                      we_n;
    logic [`SDI_SA_W-1:0]      sa;
    logic                      busy;
    logic                      rfsh_pulse;
    sdi_word_t                 rdata;
  } sdi_regs_s;

endpackage : sdi_pkg
`default_nettype wire

/* sdi_sdram_model.sv */
// Behavioural SDRAM command decoder on the memory side
`timescale 1ns/10ps
`default_nettype none
`include "sdi_params.svh"
module sdi_sdram_model (
  input  wire logic                   clk_sys,
  input  wire logic                   rstn,
  input  wire logic [`SDI_RANGES-1:0] sd_cs_n,
  input  wire logic                   sd_ras_n,
  input  wire logic                   sd_cas_n,
  input  wire logic                   sd_we_n,
  input  wire logic [`SDI_SA_W-1:0]   sd_addr,
  output var  logic [7:0]             pre_cnt,
  output var  logic [7:0]             ref_cnt,
  output var  logic [7:0]             mrs_cnt,
  output var  logic [`SDI_SA_W-1:0]   mode_q,
  output var  logic [`SDI_RANGES-1:0] cs_q
);
  wire logic act = !(&sd_cs_n) && !sd_ras_n;
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      pre_cnt <= 8'h00;
      ref_cnt <= 8'h00;
      mrs_cnt <= 8'h00;
      mode_q <= '0;
      cs_q   <= '0;
    end else if (act) begin
      cs_q <= ~sd_cs_n;
      if (sd_cas_n && !sd_we_n) pre_cnt <= pre_cnt + 8'h01;
      if (!sd_cas_n && sd_we_n) ref_cnt <= ref_cnt + 8'h01;
      if (!sd_cas_n && !sd_we_n) begin
        mrs_cnt <= mrs_cnt + 8'h01;
        mode_q <= sd_addr;
      end
    end
  end
endmodule : sdi_sdram_model
`default_nettype wire

/* sdram_power_on_init_test.sv */
// Self-checking bench for the SDRAM init sequencer
`timescale 1ns/10ps
`default_nettype none
`include "sdi_params.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_total++; \
  $display("Error %0t: got %0h expected %0h", $time, g, e); end end
bind sdi_init sdi_init_chk chk_u (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .sd_cs_n(sd_cs_n), .sd_ras_n(sd_ras_n), .sd_cas_n(sd_cas_n),
  .sd_we_n(sd_we_n), .sd_addr(sd_addr), .init_busy(init_busy), .dram_refresh_en(dram_refresh_en),
  .refresh_pulse(refresh_pulse));
module sdram_power_on_init_test;
  import sdi_pkg::*;
  logic                   clk_sys, rstn, reg_wr, reg_rd, ras_n, cas_n, we_n, busy, ref_en, pulse;
  logic [7:0]             reg_addr, pre_cnt, ref_cnt, mrs_cnt;
  sdi_word_t              reg_wdata, reg_rdata;
  logic [`SDI_RANGES-1:0] cs_n, cs_q;
  logic [`SDI_SA_W-1:0]   sa, mode_q;
  int                     err_total, compares, n;
  sdi_init dut_u (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sd_cs_n(cs_n), .sd_ras_n(ras_n),
    .sd_cas_n(cas_n), .sd_we_n(we_n), .sd_addr(sa), .init_busy(busy), .dram_refresh_en(ref_en),
    .refresh_pulse(pulse));
  sdi_sdram_model mdl_u (.clk_sys(clk_sys), .rstn(rstn), .sd_cs_n(cs_n), .sd_ras_n(ras_n),
    .sd_cas_n(cas_n), .sd_we_n(we_n), .sd_addr(sa), .pre_cnt(pre_cnt), .ref_cnt(ref_cnt), .mrs_cnt(mrs_cnt),
    .mode_q(mode_q), .cs_q(cs_q));
  // ****
  // Bus tasks and verdict
  // ****
  task automatic print_verdict;
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict
  task automatic wr(input logic [7:0] a, input sdi_word_t d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
    @(posedge clk_sys);
  endtask : wr
  task automatic rd(input logic [7:0] a, input sdi_word_t e);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
    @(posedge clk_sys);
  endtask : rd
  task automatic wait_idle(input int lim);
    for (int i = 0; i < lim; i++) begin
      @(posedge clk_sys);
      #1;
      if (busy === 1'b0 && i > 3) begin
        @(posedge clk_sys);
        return;
      end
    end
    err_total++;
    $display("Error %0t: busy wait ran out", $time);
    print_verdict();
  endtask : wait_idle
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    {rstn, reg_wr, reg_rd, reg_addr, reg_wdata, err_total, compares} = '0;
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    rd(`SDI_OFS_INIT, 32'h0);
    rd(`SDI_OFS_REFCNT, 32'h0);
    rd(8'h10, 32'h0);
    `CHK(ref_en, 1'b0)
    $display("reset test done");
    wr(`SDI_OFS_INIT, 32'h4);
    wait_idle(20);
    `CHK(ref_cnt, 8'h00)
    `CHK(ref_en, 1'b1)
    rd(`SDI_OFS_INIT, 32'h0);
    $display("no sdram test done");
    wr(`SDI_OFS_MEMTYPE, 32'h15);
    wr(`SDI_OFS_INIT, 32'h2);
    wait_idle(20);
    `CHK(pre_cnt, 8'h02)
    `CHK(cs_q, 5'h15)
    rd(`SDI_OFS_INIT, 32'h0);
    $display("precharge test done");
    wr(`SDI_OFS_INIT, 32'h4);
    wait_idle(70);
    `CHK(ref_cnt, 8'h08)
    `CHK(mrs_cnt, 8'h00)
    rd(`SDI_OFS_INIT, 32'h0);
    rd(`SDI_OFS_STATUS, 32'h2);
    $display("refresh test done");
    wr(`SDI_OFS_INIT, 32'h1);
    wait_idle(20);
    `CHK(mrs_cnt, 8'h01)
    `CHK(mode_q, `SDI_MODE_WORD)
    rd(`SDI_OFS_INIT, 32'h0);
    $display("mode test done");
    wr(`SDI_OFS_REFCNT, 32'h3);
    rd(`SDI_OFS_REFCNT, 32'h3);
    n = 0;
    repeat (40) begin
      @(posedge clk_sys);
      #1;
      if (pulse === 1'b1) n++;
    end
    `CHK(n, 10)
    $display("interval test done");
    print_verdict();
  end
endmodule : sdram_power_on_init_test
`default_nettype wire
